/* shared/admux_pkg.sv */
// Operation
// - each of eight digital pins routes to gp input, gp output or comparator output
// - pullup disable bit at 1 turns that pin's pullup off, 0 keeps it; code keeps it only after a mode write ends analog mode
// - after reset every digital pin is analog input, gp function off
// - only the control processor may read or write; other masters have no effect
// - two-bit mode field per digital pin; 00..11 select modes 0..3
// - bits 5-4 steer pin 130: 00 own gp signal, 11 comparator six
// - modes 1 and 2 reserved; software avoids them, no function given
// - mode 3 comparator map: 129-1,131-2,132-3,133-4,135-5; 128,134 none
// - mode 0 pin is a gp bit with data and per-bit direction
// - analog group one: ten pins, digital bits 2,4,6,12, no pullups
// - analog group two: ten pins, digital bits 18,20,22,28, no pullups
// - after reset all analog-group pins are analog inputs, digital off
// - odd mode bit per selectable pin: 0 digital, 1 analog input
// - group one bit 5 steers the pin of digital bit 2
// - group two bit 9 steers the pin of digital bit 20
// - even analog mode bits do not affect routing and are ignored
// - each analog-group digital bit has data and direction control
package admux_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADMUX_OFS_DMODE  = 8'h00;
    localparam logic [7:0] ADMUX_OFS_DPUD   = 8'h04;
    localparam logic [7:0] ADMUX_OFS_DDATA  = 8'h08;
    localparam logic [7:0] ADMUX_OFS_DDIR   = 8'h0C;
    localparam logic [7:0] ADMUX_OFS_AMODE1 = 8'h10;
    localparam logic [7:0] ADMUX_OFS_AMODE2 = 8'h14;
    localparam logic [7:0] ADMUX_OFS_ADATA  = 8'h18;
    localparam logic [7:0] ADMUX_OFS_ADIR   = 8'h1C;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ADMUX_RST_DMODE = 16'h0000;
    localparam logic [7:0]  ADMUX_RST_DPUD  = 8'h00;
    localparam logic [7:0]  ADMUX_RST_AN    = 8'hFF;
    localparam logic [19:0] ADMUX_RST_AMODE = 20'hFFFFF;
    // ------------------------------------------------------------
    // field positions: odd mode bits of selectable analog pins
    // ------------------------------------------------------------
    localparam int ADMUX_A_SEL0 = 5;
    localparam int ADMUX_A_SEL1 = 9;
    localparam int ADMUX_A_SEL2 = 13;
    localparam int ADMUX_A_SEL3 = 19;
    // digital bit number of the first selectable pin of each group
    localparam int ADMUX_A1_BIT0 = 2;
    localparam int ADMUX_A2_BIT0 = 18;
    // comparator index per digital pin, 0 means none
    localparam logic [23:0] ADMUX_CMP_MAP = {3'd5, 3'd0, 3'd4, 3'd3, 3'd2, 3'd6, 3'd1, 3'd0};

    typedef enum logic [1:0]
    {
        ADMUX_MODE_GP   = 2'b00,
        ADMUX_MODE_RSV1 = 2'b01,
        ADMUX_MODE_RSV2 = 2'b10,
        ADMUX_MODE_CMP  = 2'b11
    } admux_mode_e;
endpackage : admux_pkg

/* rtl/admux_pin.sv */
`timescale 1ns/1ps
`default_nettype none
module admux_pin
(
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [1:0] mode,
    input  wire logic       analog,
    input  wire logic       cmp_en,
    input  wire logic       cmp_val,
    input  wire logic       gp_out,
    input  wire logic       gp_dir,
    input  wire logic       pad_in,
    output logic            pad_out,
    output logic            pad_oe_n,
    output logic            gp_in
);
    logic drive;
    logic value;

    // ------------------------------------------------------------
    // per-pin routing
    // ------------------------------------------------------------
    always_comb
    begin
        drive = 1'b0;
        value = 1'b0;
        if (!analog)
        begin
            case (admux_pkg::admux_mode_e'(mode))
                admux_pkg::ADMUX_MODE_GP:
                begin
                    drive = gp_dir;
                    value = gp_out;
                end
                admux_pkg::ADMUX_MODE_CMP:
                begin
                    drive = cmp_en;
                    value = cmp_val;
                end
                default:
                begin
                    drive = 1'b0;
                    value = 1'b0;
                end
            endcase
        end
    end

    // outputs registered so data outputs come from flip-flops
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            pad_out  <= 1'b0;
            pad_oe_n <= 1'b1;
            gp_in    <= 1'b0;
        end
        else
        begin
            pad_out  <= value;
            pad_oe_n <= ~drive;
            gp_in    <= analog ? 1'b0 : pad_in;
        end
    end
endmodule : admux_pin
`default_nettype wire

/* rtl/admux_top.sv */
`timescale 1ns/1ps
`default_nettype none
module admux_top
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ctrl_cpu_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [6:1]  comparator_output,
    input  wire logic [7:0]  digital_pad_in,
    output logic [7:0]       digital_pad_out,
    output logic [7:0]       digital_pad_oe_n,
    output logic [7:0]       digital_pullup_en,
    output logic [7:0]       digital_analog_en,
    input  wire logic [7:0]  analog_pad_in,
    output logic [7:0]       analog_pad_out,
    output logic [7:0]       analog_pad_oe_n,
    output logic [7:0]       analog_path_en
);
    logic [15:0] digital_group_mode_select;
    logic [7:0]  digital_group_pullup_disable;
    logic [7:0]  dg_data;
    logic [7:0]  dg_dir;
    logic [7:0]  dg_analog;
    logic [19:0] analog_group_one_mode;
    logic [19:0] analog_group_two_mode;
    logic [7:0]  ag_data;
    logic [7:0]  ag_dir;
    logic [7:0]  ag_analog;
    logic [7:0]  dg_in;
    logic [7:0]  ag_in;
    logic [7:0]  dg_cmp_en;
    logic [7:0]  dg_cmp_val;
    logic        req;
    logic        wr;
    logic        rd;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // a write from another master is acked but dropped, a read returns zero
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i && wb_ctrl_cpu_i && wb_sel_i[0];
    assign rd  = req && !wb_we_i && wb_ctrl_cpu_i;

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    // ------------------------------------------------------------
    // digital group registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            digital_group_mode_select    <= admux_pkg::ADMUX_RST_DMODE;
            digital_group_pullup_disable <= admux_pkg::ADMUX_RST_DPUD;
            dg_data                      <= 8'h00;
            dg_dir                       <= 8'h00;
            dg_analog                    <= admux_pkg::ADMUX_RST_AN;
        end
        else if (wr)
        begin
            case (wb_adr_i)
                admux_pkg::ADMUX_OFS_DMODE:
                begin
                    if (wb_sel_i[1])
                        digital_group_mode_select <= wb_dat_i[15:0];
                    else
                        digital_group_mode_select[7:0] <= wb_dat_i[7:0];
                    // first mode write hands the pins over to digital use
                    dg_analog <= 8'h00;
                end
                admux_pkg::ADMUX_OFS_DPUD:  digital_group_pullup_disable <= wb_dat_i[7:0];
                admux_pkg::ADMUX_OFS_DDATA: dg_data <= wb_dat_i[7:0];
                admux_pkg::ADMUX_OFS_DDIR:  dg_dir  <= wb_dat_i[7:0];
                default:                    dg_data <= dg_data;
            endcase
        end
    end

    // ------------------------------------------------------------
    // analog group registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            analog_group_one_mode <= admux_pkg::ADMUX_RST_AMODE;
            analog_group_two_mode <= admux_pkg::ADMUX_RST_AMODE;
            ag_data               <= 8'h00;
            ag_dir                <= 8'h00;
        end
        else if (wr)
        begin
            case (wb_adr_i)
                admux_pkg::ADMUX_OFS_AMODE1:
                begin
                    analog_group_one_mode[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        analog_group_one_mode[15:8] <= wb_dat_i[15:8];
                    if (wb_sel_i[2])
                        analog_group_one_mode[19:16] <= wb_dat_i[19:16];
                end
                admux_pkg::ADMUX_OFS_AMODE2:
                begin
                    analog_group_two_mode[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        analog_group_two_mode[15:8] <= wb_dat_i[15:8];
                    if (wb_sel_i[2])
                        analog_group_two_mode[19:16] <= wb_dat_i[19:16];
                end
                admux_pkg::ADMUX_OFS_ADATA: ag_data <= wb_dat_i[7:0];
                admux_pkg::ADMUX_OFS_ADIR:  ag_dir  <= wb_dat_i[7:0];
                default:                    ag_data <= ag_data;
            endcase
        end
    end

    // only the odd select bits feed routing; even bits are stored and read back, never routed
    assign ag_analog = {analog_group_two_mode[admux_pkg::ADMUX_A_SEL3],
                        analog_group_two_mode[admux_pkg::ADMUX_A_SEL2],
                        analog_group_two_mode[admux_pkg::ADMUX_A_SEL1],
                        analog_group_two_mode[admux_pkg::ADMUX_A_SEL0],
                        analog_group_one_mode[admux_pkg::ADMUX_A_SEL3],
                        analog_group_one_mode[admux_pkg::ADMUX_A_SEL2],
                        analog_group_one_mode[admux_pkg::ADMUX_A_SEL1],
                        analog_group_one_mode[admux_pkg::ADMUX_A_SEL0]};

    // ------------------------------------------------------------
    // comparator map
    // ------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            dg_cmp_en[i]  = 1'b0;
            dg_cmp_val[i] = 1'b0;
            case (admux_pkg::ADMUX_CMP_MAP[3*i +: 3])
                3'd1: dg_cmp_val[i] = comparator_output[1];
                3'd2: dg_cmp_val[i] = comparator_output[2];
                3'd3: dg_cmp_val[i] = comparator_output[3];
                3'd4: dg_cmp_val[i] = comparator_output[4];
                3'd5: dg_cmp_val[i] = comparator_output[5];
                3'd6: dg_cmp_val[i] = comparator_output[6];
                default: dg_cmp_val[i] = 1'b0;
            endcase
            dg_cmp_en[i] = (admux_pkg::ADMUX_CMP_MAP[3*i +: 3] != 3'd0);
        end
    end

    // ------------------------------------------------------------
    // pin slices
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_dpin
            admux_pin i_admux_pin
            (
                .mclk     (mclk),
                .reset_n  (reset_n),
                .mode     (digital_group_mode_select[2*g +: 2]),
                .analog   (dg_analog[g]),
                .cmp_en   (dg_cmp_en[g]),
                .cmp_val  (dg_cmp_val[g]),
                .gp_out   (dg_data[g]),
                .gp_dir   (dg_dir[g]),
                .pad_in   (digital_pad_in[g]),
                .pad_out  (digital_pad_out[g]),
                .pad_oe_n (digital_pad_oe_n[g]),
                .gp_in    (dg_in[g])
            );
        end
        for (g = 0; g < 8; g++)
        begin : g_apin
            admux_pin i_admux_pin
            (
                .mclk     (mclk),
                .reset_n  (reset_n),
                .mode     (2'b00),
                .analog   (ag_analog[g]),
                .cmp_en   (1'b0),
                .cmp_val  (1'b0),
                .gp_out   (ag_data[g]),
                .gp_dir   (ag_dir[g]),
                .pad_in   (analog_pad_in[g]),
                .pad_out  (analog_pad_out[g]),
                .pad_oe_n (analog_pad_oe_n[g]),
                .gp_in    (ag_in[g])
            );
        end
    endgenerate

    // analog-group pins carry no pullup at all
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            digital_pullup_en <= 8'h00;
            digital_analog_en <= 8'hFF;
            analog_path_en    <= 8'hFF;
        end
        else
        begin
            digital_pullup_en <= ~digital_group_pullup_disable & ~dg_analog;
            digital_analog_en <= dg_analog;
            analog_path_en    <= ag_analog;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb
    begin
        next_rdata = 32'h00000000;
        case (wb_adr_i)
            admux_pkg::ADMUX_OFS_DMODE:  next_rdata = {16'h0000, digital_group_mode_select};
            admux_pkg::ADMUX_OFS_DPUD:   next_rdata = {24'h000000, digital_group_pullup_disable};
            admux_pkg::ADMUX_OFS_DDATA:  next_rdata = {24'h000000, dg_in};
            admux_pkg::ADMUX_OFS_DDIR:   next_rdata = {24'h000000, dg_dir};
            admux_pkg::ADMUX_OFS_AMODE1: next_rdata = {12'h000, analog_group_one_mode};
            admux_pkg::ADMUX_OFS_AMODE2: next_rdata = {12'h000, analog_group_two_mode};
            admux_pkg::ADMUX_OFS_ADATA:  next_rdata = {24'h000000, ag_in};
            admux_pkg::ADMUX_OFS_ADIR:   next_rdata = {24'h000000, ag_dir};
            default:                     next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            wb_dat_o <= 32'h00000000;
        else if (req)
            wb_dat_o <= rd ? next_rdata : 32'h00000000;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    ack_one_cycle_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle pulse");
    foreign_write_a: assert property
        (req && wb_we_i && !wb_ctrl_cpu_i |=> $stable(digital_group_mode_select)
            && $stable(dg_dir) && $stable(analog_group_one_mode))
        else $error("foreign master changed a register");
    foreign_read_a: assert property (req && !wb_ctrl_cpu_i |=> wb_dat_o == 32'h0)
        else $error("foreign master read nonzero");
    pullup_off_a: assert property
        (digital_group_pullup_disable[0] |=> !digital_pullup_en[0])
        else $error("pullup on while disabled");
    cmp_six_a: assert property
        (!dg_analog[2] && digital_group_mode_select[5:4] == 2'b11
            |=> !digital_pad_oe_n[2] && digital_pad_out[2] == $past(comparator_output[6]))
        else $error("pin 130 not driven by comparator six");
    cmp_none_a: assert property
        (digital_group_mode_select[1:0] == 2'b11 |=> digital_pad_oe_n[0])
        else $error("pin 128 driven in mode 3");
    reserved_mode_a: assert property
        (digital_group_mode_select[3:2] == 2'b01 |=> digital_pad_oe_n[1])
        else $error("reserved mode drives pin");
    analog_zero_a: assert property
        (ag_analog[1] |=> analog_pad_oe_n[1] && !ag_in[1])
        else $error("analog pin drives or reads");
    bit_nine_a: assert property
        (!analog_group_two_mode[9] && ag_dir[5] |=> !analog_pad_oe_n[5]
            && analog_pad_out[5] == $past(ag_data[5]))
        else $error("bit 20 not in digital mode");

    cov_cmp_c:     cover property (!digital_pad_oe_n[2] && digital_group_mode_select[5:4] == 2'b11);
    cov_gp_out_c:  cover property (!dg_analog[0] && !digital_pad_oe_n[0]);
    cov_ag_dig_c:  cover property (!ag_analog[0] && !analog_pad_oe_n[0]);
    cov_foreign_c: cover property (req && !wb_ctrl_cpu_i);
endmodule : admux_top
`default_nettype wire

/* verif/admux_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module admux_bench;
    // ------------------------------------------------------------
    // clock, reset, stimulus
    // ------------------------------------------------------------
    logic        mclk;
    logic        reset_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic        ctrl;
    logic [6:1]  cmp;
    logic [7:0]  dpad;
    logic [7:0]  apad;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [7:0]  d_out;
    logic [7:0]  d_oe_n;
    logic [7:0]  d_pu;
    logic [7:0]  d_an;
    logic [7:0]  a_out;
    logic [7:0]  a_oe_n;
    logic [7:0]  a_path;
    logic [31:0] rd;
    int          bad_count;
    int          num_checks;

    admux_top i_admux_top
    (
        .mclk              (mclk),
        .reset_n           (reset_n),
        .wb_cyc_i          (cyc),
        .wb_stb_i          (stb),
        .wb_we_i           (we),
        .wb_adr_i          (adr),
        .wb_sel_i          (4'hF),
        .wb_dat_i          (wdat),
        .wb_ctrl_cpu_i     (ctrl),
        .wb_dat_o          (wb_dat_o),
        .wb_ack_o          (wb_ack_o),
        .comparator_output (cmp),
        .digital_pad_in    (dpad),
        .digital_pad_out   (d_out),
        .digital_pad_oe_n  (d_oe_n),
        .digital_pullup_en (d_pu),
        .digital_analog_en (d_an),
        .analog_pad_in     (apad),
        .analog_pad_out    (a_out),
        .analog_pad_oe_n   (a_oe_n),
        .analog_path_en    (a_path)
    );

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------
    // slave timing is not assumed: wait on ack, bounded
    task wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n >= 20)
        begin
            $display("MISMATCH at %0t: no ack", $time);
            bad_count++;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb_cycle

    task wb_write(input logic [7:0] a, input logic [31:0] d);
        wb_cycle(1'b1, a, d);
        repeat (3) @(posedge mclk);
    endtask : wb_write

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
            bad_count++;
        end
    endtask : chk

    task chk_rd(input logic [7:0] a, input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h00000000);
        chk(rd, exp, "read data");
    endtask : chk_rd

    function automatic logic [7:0] exp_cmp(input logic [6:1] c);
        return {c[5], 1'b0, c[4], c[3], c[2], c[6], c[1], 1'b0};
    endfunction : exp_cmp

    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // a run that has not reached complete_run after 5000 cycles ends here as a failure
    initial
    begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        complete_run;
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [1:0] md;
        bad_count = 0;
        num_checks = 0;
        reset_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h00000000;
        ctrl = 1'b1;
        cmp = 6'h2A;
        dpad = 8'hA5;
        apad = 8'hFF;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        chk({24'h000000, d_oe_n}, 32'h000000FF, "reset oe");
        chk({24'h000000, d_an}, 32'h000000FF, "reset analog");
        chk({24'h000000, a_path}, 32'h000000FF, "reset path");
        chk({24'h000000, a_oe_n}, 32'h000000FF, "reset aoe");
        chk({24'h000000, d_pu}, 32'h00000000, "reset pullup");
        chk_rd(admux_pkg::ADMUX_OFS_DDATA, 32'h00000000);
        chk_rd(admux_pkg::ADMUX_OFS_AMODE1, 32'h000FFFFF);
        chk_rd(admux_pkg::ADMUX_OFS_DMODE, 32'h00000000);
        // other masters: acked, no effect, read zero
        ctrl <= 1'b0;
        wb_write(admux_pkg::ADMUX_OFS_AMODE1, 32'h00000000);
        wb_write(admux_pkg::ADMUX_OFS_DMODE, 32'h00000000);
        chk_rd(admux_pkg::ADMUX_OFS_AMODE2, 32'h00000000);
        ctrl <= 1'b1;
        chk({24'h000000, a_path}, 32'h000000FF, "foreign path");
        chk({24'h000000, d_an}, 32'h000000FF, "foreign mode");
        chk_rd(admux_pkg::ADMUX_OFS_AMODE1, 32'h000FFFFF);
        wb_write(8'h20, 32'hFFFFFFFF);
        chk_rd(8'h20, 32'h00000000);
        // pin 130 alone on its comparator, others gp inputs
        wb_write(admux_pkg::ADMUX_OFS_DDIR, 32'h00000000);
        wb_write(admux_pkg::ADMUX_OFS_DMODE, 32'h00000030);
        chk({24'h000000, d_an}, 32'h00000000, "mode write");
        chk({24'h000000, d_oe_n}, 32'h000000FB, "pin130 oe");
        chk({31'h00000000, d_out[2]}, {31'h00000000, cmp[6]}, "cmp6");
        // gp input readback through the input flop
        dpad <= 8'h3C;
        repeat (5) @(posedge mclk);
        chk_rd(admux_pkg::ADMUX_OFS_DDATA, 32'h0000003C);
        // pullup disable
        wb_write(admux_pkg::ADMUX_OFS_DPUD, 32'h0000000F);
        chk({24'h000000, d_pu}, 32'h000000F0, "pullup");
        chk_rd(admux_pkg::ADMUX_OFS_DPUD, 32'h0000000F);
        // every mode code on all pins; gp bits differ from comparators on pins 129,130,132,133 only
        wb_write(admux_pkg::ADMUX_OFS_DDIR, 32'h000000FF);
        wb_write(admux_pkg::ADMUX_OFS_DDATA, 32'h0000005A);
        for (int m = 0; m < 4; m++)
        begin
            md = m[1:0];
            wb_write(admux_pkg::ADMUX_OFS_DMODE, {16'h0000, {8{md}}});
            if (md == 2'b00)
            begin
                chk({24'h000000, d_oe_n}, 32'h00000000, "gp oe");
                chk({24'h000000, d_out}, 32'h0000005A, "gp out");
            end
            else if (md == 2'b11)
            begin
                chk({24'h000000, d_oe_n & 8'hBE}, 32'h00000000, "cmp oe");
                chk({24'h000000, d_out & 8'hBE}, {24'h000000, exp_cmp(cmp)},
                    "cmp map");
                cmp <= 6'h15;
                repeat (3) @(posedge mclk);
                chk({24'h000000, d_out & 8'hBE}, {24'h000000, exp_cmp(cmp)},
                    "cmp follow");
            end
            else
                chk({24'h000000, d_oe_n}, 32'h000000FF, "reserved");
        end
        // analog groups: odd bits steer, even bits ignored
        wb_write(admux_pkg::ADMUX_OFS_ADIR, 32'h000000FF);
        wb_write(admux_pkg::ADMUX_OFS_ADATA, 32'h000000C3);
        wb_write(admux_pkg::ADMUX_OFS_AMODE1, 32'h00055555);
        chk({24'h000000, a_path}, 32'h000000F0, "g1 digital");
        chk({24'h000000, a_oe_n}, 32'h000000F0, "g1 drive");
        chk({28'h0000000, a_out[3:0]}, 32'h00000003, "g1 out");
        wb_write(admux_pkg::ADMUX_OFS_AMODE1, 32'h000AAAAA);
        chk({24'h000000, a_path}, 32'h000000FF, "even ignored");
        wb_write(admux_pkg::ADMUX_OFS_AMODE1, 32'h000FFFDF);
        wb_write(admux_pkg::ADMUX_OFS_AMODE2, 32'h000FFDFF);
        chk({24'h000000, a_path}, 32'h000000DE, "bit5 bit9");
        chk({24'h000000, a_oe_n}, 32'h000000DE, "analog undriven");
        chk({30'h00000000, a_out[5], a_out[0]}, 32'h00000001, "a out");
        wb_write(admux_pkg::ADMUX_OFS_ADIR, 32'h00000000);
        repeat (5) @(posedge mclk);
        chk_rd(admux_pkg::ADMUX_OFS_ADATA, 32'h00000021);
        chk({24'h000000, a_oe_n}, 32'h000000FF, "a input");
        complete_run;
    end
endmodule : admux_bench
`default_nettype wire
